/* brs_pkg.sv */
// constants, command characters and setting layouts for the setup command interpreter
package brs_pkg;
    // command characters
    localparam logic [7:0] CH_FRAME_START = 8'h75; // u
    localparam logic [7:0] CH_FRAME_END   = 8'h76; // v
    localparam logic [7:0] CH_WRITE_NVM   = 8'h79; // y
    localparam logic [7:0] CH_ALL_ON      = 8'h58; // X
    localparam logic [7:0] CH_SYM_ON_LO   = 8'h41; // A
    localparam logic [7:0] CH_SYM_ON_HI   = 8'h47; // G
    localparam logic [7:0] CH_SYM_OFF_LO  = 8'h61; // a
    localparam logic [7:0] CH_SYM_OFF_HI  = 8'h67; // g
    localparam logic [7:0] CH_C128_ON     = 8'h57; // W
    localparam logic [7:0] CH_C128_OFF    = 8'h77; // w
    localparam logic [7:0] CH_EXP_NOCHK   = 8'h41; // A inside a frame
    localparam logic [7:0] CH_DIG_LO      = 8'h10; // ctrl-P, any length
    localparam logic [7:0] CH_DIG_HI      = 8'h3a; // colon, 42 digits
    localparam logic [7:0] CH_ICG_SHORT   = 8'h3d;
    localparam logic [7:0] CH_ICG_LONG    = 8'h3f;
    localparam logic [7:0] CH_FA_ON       = 8'h68;
    localparam logic [7:0] CH_FA_OFF      = 8'h69;
    localparam logic [7:0] CH_CD_OFF      = 8'h52;
    localparam logic [7:0] CH_CDX_ON      = 8'h53;
    localparam logic [7:0] CH_CDX_OFF     = 8'h54;
    localparam logic [7:0] CH_BUZ_ON      = 8'h4a;
    localparam logic [7:0] CH_BUZ_OFF     = 8'h4b;
    localparam logic [7:0] CH_BUZ_ONCE    = 8'h4c;
    localparam logic [7:0] CH_BEL_ON      = 8'h4d;
    localparam logic [7:0] CH_BEL_OFF     = 8'h4e;
    localparam logic [7:0] CH_SCAN_ON     = 8'h48;
    localparam logic [7:0] CH_SCAN_OFF    = 8'h49;
    localparam logic [7:0] CH_SPECIAL     = 8'h55;
    localparam logic [7:0] CH_SLEEP       = 8'h6f;
    localparam logic [7:0] CH_STOP        = 8'h70;
    localparam logic [2:0] SYM_C128_IDX   = 3'h7;

    // persistable settings, the image held in non-volatile memory
    typedef struct packed {
        logic [5:0] digits;      // 0 = any length 1..42
        logic       icg_long;
        logic [7:0] sym_en;      // c39,nw7,wpc,2of5,itf,c11,c93,c128 from bit 0
        logic       full_ascii;
        logic       cd_check;
        logic       cd_xfer;
        logic       buzz_en;
        logic       bel_en;
    } brs_persist_type;

    // state that is never written to non-volatile memory
    typedef struct packed {
        logic scan_en;
        logic special;
    } brs_volatile_type;

    localparam brs_persist_type PERSIST_RST = '{digits: 6'h00, icg_long: 1'b0,
        sym_en: 8'h1f, full_ascii: 1'b0, cd_check: 1'b0, cd_xfer: 1'b0,
        buzz_en: 1'b1, bel_en: 1'b0};
    localparam brs_volatile_type VOLATILE_RST = '{scan_en: 1'b1, special: 1'b0};

    // register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_PERSIST = 8'h08;
    localparam logic [7:0]  ADDR_VOLAT   = 8'h0c;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        CTRL_EN_RST  = 1'b1;
endpackage

/* brs_setup_cmd.sv */
// setup command interpreter of the pen reader, with an ahb-lite status port
//
// Notes on behaviour
// - outside an expanded frame each received character is decoded alone as one whole command
// - after reset the settings are reloaded from the non-volatile image
// - character y copies the active persistable settings into non-volatile memory
// - settings not committed by y live only in volatile flops
// - scan, special, sleep, stop, one-shot buzzer and frame codes never persist
// - u opens an expanded frame, one command follows, v closes it
// - A inside a frame disables check digit, keeping transfer; outside enables code39
// - ctrl-P gives any length; ctrl-Q to colon give 1 to 42 digits
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module brs_setup_cmd
    import brs_pkg::*;
(
    // clock and reset
    input  wire logic            clk_sys_in,
    input  wire logic            reset_in,
    // received command characters
    input  wire logic            rx_valid_in,
    input  wire logic [7:0]      rx_char_in,
    output logic                 rx_ready_out,
    // non-volatile memory image
    input  wire brs_persist_type nvm_data_in,
    output logic                 nvm_wr_out,
    output brs_persist_type      nvm_data_out,
    // active settings and one-cycle requests
    output brs_persist_type      persist_out,
    output brs_volatile_type     volatile_out,
    output logic                 buzz_once_out,
    output logic                 sleep_req_out,
    output logic                 stop_req_out,
    // ahb-lite slave
    input  wire logic            hsel_in,
    input  wire logic [31:0]     haddr_in,
    input  wire logic [1:0]      htrans_in,
    input  wire logic            hwrite_in,
    input  wire logic [2:0]      hsize_in,
    input  wire logic [31:0]     hwdata_in,
    input  wire logic            hready_in,
    output logic [31:0]          hrdata_out,
    output logic                 hreadyout_out,
    output logic                 hresp_out
);
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_OPEN, ST_CLOSE} brs_state_type;

    brs_state_type    state_q, state_d;
    brs_persist_type  persist_q, persist_d;
    brs_volatile_type vol_q, vol_d;
    logic             nvm_wr_q, nvm_wr_d;
    brs_persist_type  nvm_data_q, nvm_data_d;
    logic             buzz_q, buzz_d, sleep_q, sleep_d, stop_q, stop_d;
    logic [7:0]       last_q, last_d;
    logic             ctrl_en_q, ctrl_en_d;
    logic             wr_pend_q, wr_pend_d;
    logic [7:0]       waddr_q, waddr_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             accept;
    logic             hit;

    // true for a character inside an inclusive range
    function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (c >= lo) && (c <= hi);
    endfunction

    // one character per cycle; refused while the image is being reloaded
    assign accept       = rx_valid_in && rx_ready_out;
    assign rx_ready_out = ctrl_en_q && (state_q != ST_LOAD);

    // command decoder: next settings, frame state and requests
    always_comb begin
        state_d    = state_q;
        persist_d  = persist_q;
        vol_d      = vol_q;
        nvm_wr_d   = 1'b0;
        nvm_data_d = nvm_data_q;
        buzz_d     = 1'b0;
        sleep_d    = 1'b0;
        stop_d     = 1'b0;
        last_d     = last_q;
        hit        = 1'b0;
        if (state_q == ST_LOAD) begin
            persist_d = nvm_data_in;
            state_d   = ST_IDLE;
        end else if (accept) begin
            last_d = rx_char_in;
            if (state_q == ST_OPEN) begin
                hit = 1'b1;
                if (rx_char_in == CH_FRAME_END) begin
                    state_d = ST_IDLE;
                end else if (rx_char_in == CH_EXP_NOCHK) begin
                    persist_d.cd_check = 1'b0;
                    state_d            = ST_CLOSE;
                end else begin
                    hit = 1'b0;
                end
            end else if (state_q == ST_CLOSE) begin
                // only the complete code ends the frame
                hit = (rx_char_in == CH_FRAME_END);
                if (hit) begin
                    state_d = ST_IDLE;
                end
            end else begin
                hit = 1'b1;
                // digit count is the character less ctrl-P
                if (in_range(rx_char_in, CH_DIG_LO, CH_DIG_HI)) begin
                    persist_d.digits = 6'(rx_char_in - CH_DIG_LO);
                end else if (in_range(rx_char_in, CH_SYM_ON_LO, CH_SYM_ON_HI)) begin
                    // normal meaning of A is code39 enable
                    persist_d.sym_en[3'(rx_char_in - CH_SYM_ON_LO)] = 1'b1;
                end else if (in_range(rx_char_in, CH_SYM_OFF_LO, CH_SYM_OFF_HI)) begin
                    persist_d.sym_en[3'(rx_char_in - CH_SYM_OFF_LO)] = 1'b0;
                end else if (rx_char_in == CH_C128_ON) begin
                    persist_d.sym_en[SYM_C128_IDX] = 1'b1;
                end else if (rx_char_in == CH_C128_OFF) begin
                    persist_d.sym_en[SYM_C128_IDX] = 1'b0;
                end else if (rx_char_in == CH_ALL_ON) begin
                    persist_d.sym_en = '1;
                end else if (rx_char_in == CH_ICG_SHORT) begin
                    persist_d.icg_long = 1'b0;
                end else if (rx_char_in == CH_ICG_LONG) begin
                    persist_d.icg_long = 1'b1;
                end else if (rx_char_in == CH_FA_ON) begin
                    persist_d.full_ascii = 1'b1;
                end else if (rx_char_in == CH_FA_OFF) begin
                    persist_d.full_ascii = 1'b0;
                end else if (rx_char_in == CH_CD_OFF) begin
                    persist_d.cd_check = 1'b0;
                    persist_d.cd_xfer  = 1'b0;
                end else if (rx_char_in == CH_CDX_ON) begin
                    persist_d.cd_check = 1'b1;
                    persist_d.cd_xfer  = 1'b1;
                end else if (rx_char_in == CH_CDX_OFF) begin
                    persist_d.cd_check = 1'b1;
                    persist_d.cd_xfer  = 1'b0;
                end else if (rx_char_in == CH_BUZ_ON) begin
                    persist_d.buzz_en = 1'b1;
                end else if (rx_char_in == CH_BUZ_OFF) begin
                    persist_d.buzz_en = 1'b0;
                end else if (rx_char_in == CH_BEL_ON) begin
                    persist_d.bel_en = 1'b1;
                end else if (rx_char_in == CH_BEL_OFF) begin
                    persist_d.bel_en = 1'b0;
                end else if (rx_char_in == CH_BUZ_ONCE) begin
                    // volatile requests, kept out of the image
                    buzz_d = 1'b1;
                end else if (rx_char_in == CH_SCAN_ON) begin
                    vol_d.scan_en = 1'b1;
                    vol_d.special = 1'b0;
                end else if (rx_char_in == CH_SCAN_OFF) begin
                    vol_d.scan_en = 1'b0;
                end else if (rx_char_in == CH_SPECIAL) begin
                    vol_d.special = 1'b1;
                end else if (rx_char_in == CH_SLEEP) begin
                    sleep_d = 1'b1;
                end else if (rx_char_in == CH_STOP) begin
                    stop_d = 1'b1;
                end else if (rx_char_in == CH_FRAME_START) begin
                    state_d = ST_OPEN;
                end else if (rx_char_in == CH_WRITE_NVM) begin
                    nvm_wr_d   = 1'b1;
                    nvm_data_d = persist_q;
                end else begin
                    hit = 1'b0;
                end
            end
        end
    end

    // settings live in flops until committed
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q    <= ST_LOAD;
            persist_q  <= PERSIST_RST;
            vol_q      <= VOLATILE_RST;
            nvm_wr_q   <= 1'b0;
            nvm_data_q <= PERSIST_RST;
            buzz_q     <= 1'b0;
            sleep_q    <= 1'b0;
            stop_q     <= 1'b0;
            last_q     <= 8'h00;
        end else begin
            state_q    <= state_d;
            persist_q  <= persist_d;
            vol_q      <= vol_d;
            nvm_wr_q   <= nvm_wr_d;
            nvm_data_q <= nvm_data_d;
            buzz_q     <= buzz_d;
            sleep_q    <= sleep_d;
            stop_q     <= stop_d;
            last_q     <= last_d;
        end
    end

    assign nvm_wr_out    = nvm_wr_q;
    assign nvm_data_out  = nvm_data_q;
    assign persist_out   = persist_q;
    assign volatile_out  = vol_q;
    assign buzz_once_out = buzz_q;
    assign sleep_req_out = sleep_q;
    assign stop_req_out  = stop_q;

    // bus slave: zero wait, read data captured in the address phase
    always_comb begin
        wr_pend_d = 1'b0;
        waddr_d   = waddr_q;
        rdata_d   = rdata_q;
        ctrl_en_d = ctrl_en_q;
        if (wr_pend_q && waddr_q == ADDR_CTRL) begin
            ctrl_en_d = hwdata_in[0];
        end
        if (hready_in && hsel_in && htrans_in == HTRANS_NONSEQ) begin
            wr_pend_d = hwrite_in;
            waddr_d   = haddr_in[7:0];
            if (haddr_in[7:0] == ADDR_CTRL) begin
                rdata_d = {31'h0, ctrl_en_q};
            end else if (haddr_in[7:0] == ADDR_STATUS) begin
                rdata_d = {22'h0, state_q, last_q};
            end else if (haddr_in[7:0] == ADDR_PERSIST) begin
                rdata_d = {12'h0, persist_q};
            end else if (haddr_in[7:0] == ADDR_VOLAT) begin
                rdata_d = {30'h0, vol_q};
            end else begin
                rdata_d = 32'h0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 8'h00;
            rdata_q   <= 32'h0;
            ctrl_en_q <= CTRL_EN_RST;
        end else begin
            wr_pend_q <= wr_pend_d;
            waddr_q   <= waddr_d;
            rdata_q   <= rdata_d;
            ctrl_en_q <= ctrl_en_d;
        end
    end

    assign hrdata_out    = rdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    // checks on decoded behaviour
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_idle_char(logic [7:0] c);
        accept && state_q == ST_IDLE && rx_char_in == c;
    endsequence
    sequence s_frame_a;
        accept && state_q == ST_IDLE && rx_char_in == CH_FRAME_START
        ##1 accept && rx_char_in == CH_EXP_NOCHK;
    endsequence

    restore_load_a: assert property (state_q == ST_LOAD |=>
        persist_q == $past(nvm_data_in) && state_q == ST_IDLE)
        else $error("settings not reloaded after reset");
    nvm_commit_a: assert property (s_idle_char(CH_WRITE_NVM) |=>
        nvm_wr_q && nvm_data_q == $past(persist_q) ##1 (!nvm_wr_q
        || $past(accept && state_q == ST_IDLE && rx_char_in == CH_WRITE_NVM)))
        else $error("write command did not commit settings");
    nvm_quiet_a: assert property (accept && rx_char_in != CH_WRITE_NVM |=>
        !nvm_wr_q)
        else $error("memory written without write command");
    volatile_only_a: assert property (s_idle_char(CH_SCAN_OFF) |=>
        !vol_q.scan_en && persist_q == $past(persist_q))
        else $error("scan disable touched persistable state");
    frame_exp_a: assert property (s_frame_a |=>
        state_q == ST_CLOSE && !persist_q.cd_check
        && persist_q.cd_xfer == $past(persist_q.cd_xfer))
        else $error("expanded A mishandled");
    normal_a_a: assert property (s_idle_char(CH_SYM_ON_LO) |=>
        persist_q.sym_en[0] && persist_q.cd_check == $past(persist_q.cd_check))
        else $error("normal A did not enable code39");
    all_on_a: assert property (s_idle_char(CH_ALL_ON) |=>
        persist_q.sym_en == 8'hff)
        else $error("all symbologies not enabled");
    digit_count_a: assert property (accept && state_q == ST_IDLE
        && in_range(rx_char_in, CH_DIG_LO, CH_DIG_HI)
        |=> persist_q.digits == 6'($past(rx_char_in) - CH_DIG_LO))
        else $error("digit count decoded wrongly");
    unknown_char_a: assert property (accept && !hit |=>
        persist_q == $past(persist_q) && vol_q == $past(vol_q))
        else $error("unmatched character changed settings");
endmodule

/* brs_host_model.sv */
// host terminal model that sends setup command characters
`timescale 1ns/1ps
module brs_host_model (
    // clock
    input  wire logic       clk_sys_in,
    // character port
    input  wire logic       rx_ready_in,
    output logic            rx_valid_out,
    output logic [7:0]      rx_char_out,
    output logic            stuck_out
);
    // idle at time zero
    initial begin
        rx_valid_out = 1'b0;
        rx_char_out  = 8'h00;
        stuck_out    = 1'b0;
    end

    // idle for gap plus one cycles, then all n characters go back to back
    task automatic send(input logic [31:0] chars, input int n, input int gap);
        int k;
        repeat (gap + 1) @(posedge clk_sys_in);
        for (int i = n - 1; i >= 0; i--) begin
            rx_valid_out <= 1'b1;
            rx_char_out  <= chars[8*i +: 8];
            k = 0;
            do begin
                @(posedge clk_sys_in);
                k++;
            end while (rx_ready_in !== 1'b1 && k < 40);
            if (k >= 40) stuck_out <= 1'b1;
        end
        rx_valid_out <= 1'b0;
        // flip the idle byte so a stale character never looks fresh
        rx_char_out  <= ~rx_char_out;
    endtask
endmodule

/* tb.sv */
// self-checking bench for the setup command interpreter
`timescale 1ns/1ps
module tb;
    import brs_pkg::*;
    // digit command table and the lengths they select
    localparam logic [7:0] DCH [7] = '{8'h10, 8'h11, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h3a};
    localparam logic [5:0] DLN [7] = '{6'h00, 6'h01, 6'h0f, 6'h10, 6'h1f, 6'h20, 6'h2a};
    logic             clk_sys_in = 1'b0;
    logic             reset_in   = 1'b1;
    logic             hsel       = 1'b0;
    logic [31:0]      haddr      = 32'h0;
    logic [1:0]       htrans     = 2'h0;
    logic             hwrite     = 1'b0;
    logic [31:0]      hwdata     = 32'h0;
    brs_persist_type  nvm_in     = PERSIST_RST;
    brs_persist_type  nvm_out, nvm_img, persist, exp_p;
    brs_volatile_type volat;
    logic [31:0]      hrdata;
    logic             rx_valid, rx_ready, stuck, nvm_wr, buzz1, sleep_rq, stop_rq;
    logic             hready, hresp;
    logic [7:0]       rx_char;
    int               mismatches = 0;
    int               tests_run  = 0;
    int               n_wr, n_buzz, n_sleep, n_stop;

    always #2 clk_sys_in = ~clk_sys_in;

    brs_setup_cmd uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .rx_valid_in(rx_valid),
        .rx_char_in(rx_char), .rx_ready_out(rx_ready), .nvm_data_in(nvm_in),
        .nvm_wr_out(nvm_wr), .nvm_data_out(nvm_out), .persist_out(persist),
        .volatile_out(volat), .buzz_once_out(buzz1), .sleep_req_out(sleep_rq),
        .stop_req_out(stop_rq), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp));

    brs_host_model host (.clk_sys_in(clk_sys_in), .rx_ready_in(rx_ready),
        .rx_valid_out(rx_valid), .rx_char_out(rx_char), .stuck_out(stuck));

    // the eeprom keeps whatever is written; pulses are counted per cycle high
    always @(posedge clk_sys_in) begin
        if (nvm_wr === 1'b1) nvm_img <= nvm_out;
        if (nvm_wr === 1'b1) n_wr++;
        if (buzz1 === 1'b1) n_buzz++;
        if (sleep_rq === 1'b1) n_sleep++;
        if (stop_rq === 1'b1) n_stop++;
    end

    task automatic close_out();
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // send characters, then let one more edge pass so pulses are counted
    task automatic tx(input logic [31:0] c, input int n);
        host.send(c, n, n - 1);
        repeat (2) @(negedge clk_sys_in);
        if (stuck !== 1'b0) begin
            mismatches++;
            close_out();
        end
    endtask

    task automatic cmp_set();
        chk(32'(persist), 32'(exp_p));
    endtask

    // one single ahb-lite transfer, both phases bounded
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        @(posedge clk_sys_in);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        k = 0;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (hready !== 1'b1 && k < 40);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (hready !== 1'b1 && k < 80);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
        if (k >= 80) begin
            mismatches++;
            close_out();
        end
        @(negedge clk_sys_in);
    endtask

    task automatic power_on(input brs_persist_type img);
        @(posedge clk_sys_in);
        nvm_in   <= img;
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask

    task automatic t_restore();
        logic [31:0] rd;
        exp_p = '{6'h05, 1'b1, 8'h03, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        power_on(exp_p);
        cmp_set();
        chk(32'(volat), 32'(VOLATILE_RST));
        ahb(1'b0, ADDR_PERSIST, 32'h0, rd);
        chk(rd, 32'(exp_p));
        tx(32'h58, 1);
        exp_p.sym_en = 8'hff;
        cmp_set();
    endtask

    task automatic t_digits();
        for (int i = 0; i < 7; i++) begin
            tx(32'(DCH[i]), 1);
            exp_p.digits = DLN[i];
            cmp_set();
        end
    endtask

    task automatic t_frame();
        tx(32'h6153, 2);
        exp_p.sym_en[0] = 1'b0;
        exp_p.cd_check = 1'b1;
        exp_p.cd_xfer = 1'b1;
        cmp_set();
        tx(32'h754176, 3);
        exp_p.cd_check = 1'b0;
        cmp_set();
        tx(32'h755876, 3);
        cmp_set();
        tx(32'h41, 1);
        exp_p.sym_en[0] = 1'b1;
        cmp_set();
        tx(32'h7e00, 2);
        cmp_set();
        chk(32'(volat), 32'(VOLATILE_RST));
    endtask

    task automatic t_persist();
        brs_persist_type saved;
        tx(32'h4955, 2);
        chk(32'(volat), 32'h1);
        n_buzz = 0;
        n_sleep = 0;
        n_stop = 0;
        tx(32'h4c6f70, 3);
        chk(32'(n_buzz + n_sleep * 16 + n_stop * 256), 32'h111);
        cmp_set();
        n_wr = 0;
        tx(32'h79, 1);
        chk(32'(n_wr), 32'h1);
        chk(32'(nvm_img), 32'(exp_p));
        saved = exp_p;
        tx(32'h4a, 1);
        exp_p.buzz_en = 1'b1;
        cmp_set();
        power_on(nvm_img);
        chk(32'(persist), 32'(saved));
        chk(32'(volat), 32'(VOLATILE_RST));
        exp_p = saved;
    endtask

    // the remaining normal setting commands except symbologies B to G and b to g, each group checked as a whole
    task automatic t_normal();
        tx(32'h773d694e, 4);
        exp_p.sym_en[7] = 1'b0;
        exp_p.icg_long = 1'b0;
        exp_p.full_ascii = 1'b0;
        exp_p.bel_en = 1'b0;
        cmp_set();
        tx(32'h573f684a, 4);
        exp_p.sym_en[7] = 1'b1;
        exp_p.icg_long = 1'b1;
        exp_p.full_ascii = 1'b1;
        exp_p.buzz_en = 1'b1;
        cmp_set();
        tx(32'h52, 1);
        exp_p.cd_check = 1'b0;
        exp_p.cd_xfer = 1'b0;
        cmp_set();
        tx(32'h544d4b, 3);
        exp_p.cd_check = 1'b1;
        exp_p.bel_en = 1'b1;
        exp_p.buzz_en = 1'b0;
        cmp_set();
        tx(32'h5548, 2);
        chk(32'(volat), 32'(VOLATILE_RST));
        cmp_set();
    endtask

    task automatic t_bus();
        logic [31:0] rd;
        ahb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk(rd, 32'(CTRL_EN_RST));
        ahb(1'b1, ADDR_CTRL, 32'h0, rd);
        chk(32'(rx_ready), 32'h0);
        ahb(1'b1, ADDR_CTRL, 32'h1, rd);
        ahb(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
        tx(32'h58, 1);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd, 32'h158);
    endtask

    // main sequence
    initial begin
        t_restore();
        t_digits();
        t_frame();
        t_persist();
        t_normal();
        t_bus();
        close_out();
    end
endmodule
